// ==== pisc_defs.vh ====
// Constants for the event status, configuration and receive error counter bank
`ifndef PISC_DEFS_VH
`define PISC_DEFS_VH
// Register offsets on the management port
`define PISC_ADDR_W           5
`define PISC_OFF_EVENT_STATUS 5'h13
`define PISC_OFF_CONFIG_TWO   5'h14
`define PISC_OFF_RX_ERR_CNT   5'h15
// Event status bit positions
`define PISC_EV_AN_ERROR      15
`define PISC_EV_SPEED_CHG     14
`define PISC_EV_DUPLEX_CHG    13
`define PISC_EV_PAGE_RX       12
`define PISC_EV_AN_COMPLETE   11
`define PISC_EV_LINK_CHG      10
`define PISC_EV_FALSE_CARRIER 8
`define PISC_EV_CROSSOVER_CHG 6
`define PISC_EV_SPEED_FALLBK  5
`define PISC_EV_SLEEP_CHG     4
`define PISC_EV_WAKE_PACKET   3
`define PISC_EV_MAC_IF_ERROR  2
`define PISC_EV_POLARITY_CHG  1
`define PISC_EV_JABBER        0
// Implemented event bits; 9 and 7 are reserved
`define PISC_EV_MASK          16'hFD7F
`define PISC_EV_RESET         16'h0000
// Configuration field positions
`define PISC_CFG_INT_POL      13
`define PISC_CFG_LIMIT_HI     11
`define PISC_CFG_LIMIT_LO     10
`define PISC_CFG_FB_EN        9
`define PISC_CFG_FB_ENH       8
`define PISC_CFG_SER_AN       7
`define PISC_CFG_FB_TEN       6
// Configuration reset values
`define PISC_RST_INT_POL      1'b1
`define PISC_RST_LIMIT        2'h2
`define PISC_RST_FB_EN        1'b0
`define PISC_RST_FB_ENH       1'b1
`define PISC_RST_SER_AN       1'b1
`define PISC_RST_FB_TEN       1'b1
// Read-only low field of the configuration register
`define PISC_CFG_LOW_RO       6'h07
// Receive error counter
`define PISC_CNT_MAX          16'hFFFF
`define PISC_CNT_RESET        16'h0000
`endif

// ==== pisc_fallback.v ====
// Speed optimization fallback decision: failed gigabit attempts and ten megabit step
`timescale 1ns/1ps
`default_nettype none
`include "pisc_defs.vh"
module pisc_fallback (
   input  wire       clk,
   input  wire       rstn,
   input  wire       fallback_enable,
   input  wire       fallback_enhanced_enable,
   input  wire       fallback_to_ten_enable,
   input  wire [1:0] fallback_attempt_limit,
   input  wire       gig_attempt_fail,
   input  wire       fast_attempt_fail,
   input  wire       cd_no_energy,
   input  wire       fallback_restart,
   output reg        mask_gig,
   output reg        drop_to_ten,
   output reg        fallback_pulse
);

   reg [3:0] fail_cnt_q;      // Failed gigabit attempts so far
   reg [3:0] fail_cnt_d;

   //////////////////////////////////////////////////////////////////////////
   // Decode of the attempt field into a count
   function [3:0] pisc_limit;
      input [1:0] code;
      begin
         case (code)
            2'h3:    pisc_limit = 4'h8;
            2'h2:    pisc_limit = 4'h4;
            2'h1:    pisc_limit = 4'h2;
            default: pisc_limit = 4'h1;
         endcase
      end
   endfunction

   // Next attempt count, compared against the limit
   always @* begin
      fail_cnt_d = fail_cnt_q + 4'h1;
   end

   //////////////////////////////////////////////////////////////////////////
   // Attempt counting and fallback state
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         fail_cnt_q     <= 4'h0;
         mask_gig       <= 1'b0;
         drop_to_ten    <= 1'b0;
         fallback_pulse <= 1'b0;
      end else begin
         fallback_pulse <= 1'b0;
         if (!fallback_enable || fallback_restart) begin
            // Disabling or restarting drops all masking
            fail_cnt_q  <= 4'h0;
            mask_gig    <= 1'b0;
            drop_to_ten <= 1'b0;
         end else if (gig_attempt_fail && !mask_gig) begin
            if (fallback_enhanced_enable && cd_no_energy) begin
               // No energy on pairs C and D: gigabit is hopeless now
               mask_gig       <= 1'b1;
               fallback_pulse <= 1'b1;
               fail_cnt_q     <= 4'h0;
            end else if (fail_cnt_d >= pisc_limit(fallback_attempt_limit)) begin
               mask_gig       <= 1'b1;
               fallback_pulse <= 1'b1;
               fail_cnt_q     <= 4'h0;
            end else begin
               fail_cnt_q <= fail_cnt_d;
            end
         end else if (fast_attempt_fail && mask_gig && !drop_to_ten && fallback_to_ten_enable) begin
            // Both faster rates failed, step down once more
            drop_to_ten    <= 1'b1;
            fallback_pulse <= 1'b1;
         end
      end
   end

endmodule
`default_nettype wire

// ==== pisc_regs.v ====
// Event status, configuration two and receive error counter register bank
//
// How it works
// - Status bits set regardless of enables
// - Bits latch until status read clears them
// - Upper event positions fifteen down to ten
// - Lower event positions eight down to zero, seven reserved
// - MAC error covers only the MAC interface in use
// - Bit thirteen picks pin polarity, default low
// - Bits fifteen, fourteen, twelve read zero
// - Fallback after selected failed gigabit attempts
// - Enhanced mode falls back without C/D energy
// - Bit seven enables serial MAC negotiation
// - Bit six allows stepping down to ten
// - Sixteen-bit error counter saturates, never wraps
// - Any write clears counter; reads do not
// - Pin asserts on set and enabled event
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "pisc_defs.vh"
module pisc_regs (
   input  wire                     clk,
   input  wire                     rstn,
   // Management register port
   input  wire [`PISC_ADDR_W-1:0]  reg_addr,
   input  wire [15:0]              reg_wdata,
   input  wire                     reg_wr,
   input  wire                     reg_rd,
   output reg  [15:0]              reg_rdata,
   // Enables held by the neighbouring enable register
   input  wire [15:0]              interrupt_enable_reg,
   // One-cycle event pulses from the line and MAC logic
   input  wire                     an_error_event,
   input  wire                     speed_change_event,
   input  wire                     duplex_change_event,
   input  wire                     page_rx_event,
   input  wire                     an_complete_event,
   input  wire                     link_change_event,
   input  wire                     false_carrier_event,
   input  wire                     crossover_change_event,
   input  wire                     speed_fallback_event,
   input  wire                     sleep_change_event,
   input  wire                     wake_packet_event,
   input  wire                     rgmii_error_event,
   input  wire                     sgmii_error_event,
   input  wire                     sgmii_active,
   input  wire                     polarity_change_event,
   input  wire                     jabber_event,
   // Receive error indication toward the MAC
   input  wire                     rx_error,
   // Speed optimization inputs
   input  wire                     gig_attempt_fail,
   input  wire                     fast_attempt_fail,
   input  wire                     cd_no_energy,
   input  wire                     fallback_restart,
   // Outputs
   output reg                      int_pin,
   output wire                     serial_mac_an_enable,
   output wire                     fallback_mask_gig,
   output wire                     fallback_drop_to_ten
);

   ///////////////////////////////////////////////////////////////////////////
   // State
   reg  [15:0] event_status_q;            // Latched event bits
   reg  [15:0] event_status_d;
   reg  [15:0] event_set;                 // This cycle's events
   reg         int_polarity_q;            // One: pin active low
   reg  [1:0]  fallback_attempt_limit_q;  // Attempt count code
   reg         fallback_enable_q;         // Speed optimization on
   reg         fallback_enhanced_enable_q;// Enhanced mode on
   reg         serial_mac_an_enable_q;    // Serial MAC negotiation on
   reg         fallback_to_ten_enable_q;  // Ten megabit step allowed
   reg  [15:0] rx_error_count_q;          // Saturating error count
   reg  [15:0] rx_error_count_d;
   reg  [15:0] rdata_d;                   // Read mux result
   wire [15:0] config_two_rd;             // Configuration as read
   wire        fb_pulse;                  // Internal fallback event
   wire        irq_active;                // Any enabled pending event
   wire        rd_status;                 // Status read this cycle
   wire        wr_config;
   wire        wr_counter;

   assign rd_status  = reg_rd && (reg_addr == `PISC_OFF_EVENT_STATUS);
   assign wr_config  = reg_wr && (reg_addr == `PISC_OFF_CONFIG_TWO);
   assign wr_counter = reg_wr && (reg_addr == `PISC_OFF_RX_ERR_CNT);

   ///////////////////////////////////////////////////////////////////////////
   // Speed optimization engine
   pisc_fallback u_fallback (
      .clk                      (clk),
      .rstn                     (rstn),
      .fallback_enable          (fallback_enable_q),
      .fallback_enhanced_enable (fallback_enhanced_enable_q),
      .fallback_to_ten_enable   (fallback_to_ten_enable_q),
      .fallback_attempt_limit   (fallback_attempt_limit_q),
      .gig_attempt_fail         (gig_attempt_fail),
      .fast_attempt_fail        (fast_attempt_fail),
      .cd_no_energy             (cd_no_energy),
      .fallback_restart         (fallback_restart),
      .mask_gig                 (fallback_mask_gig),
      .drop_to_ten              (fallback_drop_to_ten),
      .fallback_pulse           (fb_pulse)
   );

   assign serial_mac_an_enable = serial_mac_an_enable_q;

   ///////////////////////////////////////////////////////////////////////////
   // Event gathering into bit positions
   always @* begin
      event_set = 16'h0000;
      event_set[`PISC_EV_AN_ERROR]      = an_error_event;
      event_set[`PISC_EV_SPEED_CHG]     = speed_change_event;
      event_set[`PISC_EV_DUPLEX_CHG]    = duplex_change_event;
      event_set[`PISC_EV_PAGE_RX]       = page_rx_event;
      event_set[`PISC_EV_AN_COMPLETE]   = an_complete_event;
      event_set[`PISC_EV_LINK_CHG]      = link_change_event;
      event_set[`PISC_EV_FALSE_CARRIER] = false_carrier_event;
      event_set[`PISC_EV_CROSSOVER_CHG] = crossover_change_event;
      // Own engine's fallback also counts as this event
      event_set[`PISC_EV_SPEED_FALLBK]  = speed_fallback_event | fb_pulse;
      event_set[`PISC_EV_SLEEP_CHG]     = sleep_change_event;
      event_set[`PISC_EV_WAKE_PACKET]   = wake_packet_event;
      // Only the interface in use reports errors
      event_set[`PISC_EV_MAC_IF_ERROR]  = sgmii_active ? sgmii_error_event : rgmii_error_event;
      event_set[`PISC_EV_POLARITY_CHG]  = polarity_change_event;
      event_set[`PISC_EV_JABBER]        = jabber_event;
   end

   ///////////////////////////////////////////////////////////////////////////
   // Latch and clear-on-read; enables play no part here
   always @* begin
      event_status_d = event_status_q;
      if (rd_status) begin
         event_status_d = 16'h0000;
      end
      // Set after clear so a coincident event survives the read
      event_status_d = (event_status_d | event_set) & `PISC_EV_MASK;
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         event_status_q <= `PISC_EV_RESET;
      end else begin
         event_status_q <= event_status_d;
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // Configuration register writes
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         int_polarity_q             <= `PISC_RST_INT_POL;
         fallback_attempt_limit_q   <= `PISC_RST_LIMIT;
         fallback_enable_q          <= `PISC_RST_FB_EN;
         fallback_enhanced_enable_q <= `PISC_RST_FB_ENH;
         serial_mac_an_enable_q     <= `PISC_RST_SER_AN;
         fallback_to_ten_enable_q   <= `PISC_RST_FB_TEN;
      end else if (wr_config) begin
         // Reserved bits are simply not stored
         int_polarity_q             <= reg_wdata[`PISC_CFG_INT_POL];
         fallback_attempt_limit_q   <= reg_wdata[`PISC_CFG_LIMIT_HI:`PISC_CFG_LIMIT_LO];
         fallback_enable_q          <= reg_wdata[`PISC_CFG_FB_EN];
         fallback_enhanced_enable_q <= reg_wdata[`PISC_CFG_FB_ENH];
         serial_mac_an_enable_q     <= reg_wdata[`PISC_CFG_SER_AN];
         fallback_to_ten_enable_q   <= reg_wdata[`PISC_CFG_FB_TEN];
      end
   end

   // Readback: 15:14 and 12 zero, low field fixed
   assign config_two_rd = {2'b00, int_polarity_q, 1'b0, fallback_attempt_limit_q,
                           fallback_enable_q, fallback_enhanced_enable_q,
                           serial_mac_an_enable_q, fallback_to_ten_enable_q,
                           `PISC_CFG_LOW_RO};

   ///////////////////////////////////////////////////////////////////////////
   // Receive error counter; a write beats a same-cycle error
   always @* begin
      rx_error_count_d = rx_error_count_q;
      if (wr_counter) begin
         rx_error_count_d = `PISC_CNT_RESET;
      end else if (rx_error && (rx_error_count_q != `PISC_CNT_MAX)) begin
         rx_error_count_d = rx_error_count_q + 16'h0001;
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rx_error_count_q <= `PISC_CNT_RESET;
      end else begin
         rx_error_count_q <= rx_error_count_d;
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // Read mux; unmapped addresses read zero
   always @* begin
      case (reg_addr)
         `PISC_OFF_EVENT_STATUS: rdata_d = event_status_q;
         `PISC_OFF_CONFIG_TWO:   rdata_d = config_two_rd;
         `PISC_OFF_RX_ERR_CNT:   rdata_d = rx_error_count_q;
         default:                rdata_d = 16'h0000;
      endcase
   end

   // Data holds only in the cycle after the read
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         reg_rdata <= rdata_d;
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // Interrupt pin, registered to keep it glitch free
   assign irq_active = |(event_status_q & interrupt_enable_reg);

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         int_pin <= 1'b1; // Idle level for the default active-low pin
      end else begin
         int_pin <= int_polarity_q ? ~irq_active : irq_active;
      end
   end

endmodule
`default_nettype wire

// ==== pisc_regs_props.sv ====
// Concurrent checks on the register bank ports
`timescale 1ns/1ps
`default_nettype none
`include "pisc_defs.vh"
module pisc_regs_props (
   input wire logic                    clk,
   input wire logic                    rstn,
   input wire logic [`PISC_ADDR_W-1:0] reg_addr,
   input wire logic                    reg_wr,
   input wire logic                    reg_rd,
   input wire logic [15:0]             reg_rdata,
   input wire logic                    rx_error,
   input wire logic                    link_change_event,
   input wire logic                    serial_mac_an_enable
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // Decoded strobes: a read for each register, a write for the counter
   wire logic rd_st = reg_rd && reg_addr == `PISC_OFF_EVENT_STATUS;
   wire logic rd_cf = reg_rd && reg_addr == `PISC_OFF_CONFIG_TWO;
   wire logic rd_ct = reg_rd && reg_addr == `PISC_OFF_RX_ERR_CNT;
   wire logic wr_ct = reg_wr && reg_addr == `PISC_OFF_RX_ERR_CNT;
   // Second of two reads sees the first plus errors taken at the first edge
   property p_step;
      rd_ct ##1 rd_ct |=> reg_rdata == ($past(reg_rdata) == `PISC_CNT_MAX ? `PISC_CNT_MAX :
         $past(reg_rdata) + {15'h0, $past(rx_error, 2)});
   endproperty
   chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data not zero outside a read");
   chk_resv_zero: assert property (rd_st |=> !reg_rdata[9] && !reg_rdata[7])
      else $error("reserved status bit set");
   chk_cfg_fixed: assert property (rd_cf |=> reg_rdata[15:14] == 2'h0 && !reg_rdata[12])
      else $error("fixed config bits not zero");
   chk_an_follow: assert property (rd_cf |=> reg_rdata[7] == serial_mac_an_enable)
      else $error("negotiation enable differs from config bit");
   chk_link_latch: assert property (link_change_event ##1 rd_st |=> reg_rdata[10])
      else $error("link event lost");
   chk_read_clear: assert property (rd_st && !link_change_event ##1 rd_st |=> !reg_rdata[10])
      else $error("status bit survived a read");
   chk_cnt_clear: assert property (wr_ct ##1 rd_ct |=> reg_rdata == 16'h0000)
      else $error("counter not cleared by write");
   chk_cnt_step: assert property (p_step)
      else $error("counter step wrong");
   cover property (rd_st ##1 rd_st);
   cover property (wr_ct ##1 rd_ct);
   cover property (rd_ct && rx_error ##1 rd_ct);
endmodule
bind pisc_regs pisc_regs_props i_props (.clk, .rstn, .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .rx_error,
   .link_change_event, .serial_mac_an_enable);
`default_nettype wire

// ==== pisc_host.sv ====
// Management host model driving the plain register port
`timescale 1ns/1ps
`default_nettype none
`include "pisc_defs.vh"
module pisc_host (
   input  wire logic                    clk,
   input  wire logic [15:0]             reg_rdata,
   output logic      [`PISC_ADDR_W-1:0] reg_addr,
   output logic      [15:0]             reg_wdata,
   output logic                         reg_wr,
   output logic                         reg_rd
);
   // Idle bus from time zero
   initial begin
      reg_addr = '0;
      reg_wdata = '0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // One-cycle write; any data clears the counter, so callers need no special value
   task automatic wr(input logic [`PISC_ADDR_W-1:0] a, input logic [15:0] d);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // Two back-to-back reads; each answer taken at the edge after its strobe
   task automatic rd(input logic [`PISC_ADDR_W-1:0] a, output logic [15:0] d1, output logic [15:0] d2);
      reg_rd <= 1'b1;
      reg_addr <= a;
      repeat (2) @(posedge clk);
      reg_rd <= 1'b0;
      d1 = reg_rdata;
      @(posedge clk);
      d2 = reg_rdata;
   endtask
endmodule
`default_nettype wire

// ==== pisc_regs_tb.sv ====
// Self-checking bench for the status, config and counter bank
`timescale 1ns/1ps
`default_nettype none
`include "pisc_defs.vh"
module pisc_regs_tb;
   logic                    clk = 1'b0;
   logic                    rstn = 1'b0;
   wire logic [`PISC_ADDR_W-1:0] reg_addr;
   wire logic [15:0]        reg_wdata, reg_rdata;
   wire logic               reg_wr, reg_rd, int_pin, serial_mac_an_enable;
   wire logic               fallback_mask_gig, fallback_drop_to_ten;
   logic [15:0]             ev = 16'h0000;    // Event pulses by status position; 9, 7 feed the two MAC errors
   logic [15:0]             ien = 16'h0000;   // Interrupt enables
   logic                    sg = 1'b0;        // Serial MAC in use
   logic                    rx_error = 1'b0, gig_attempt_fail = 1'b0, fast_attempt_fail = 1'b0;
   logic                    cd_no_energy = 1'b0, fallback_restart = 1'b0;
   logic [15:0]             d1, d2;           // Read answers
   logic [32:0]             rows[$];          // Serial select, event pulses, expected status
   int                      bad_count = 0, compares = 0, cycles = 0;
   initial forever #2.5 clk = ~clk;
   pisc_host i_host (.clk, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
   pisc_regs i_dut (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .interrupt_enable_reg(ien),
      .an_error_event(ev[15]), .speed_change_event(ev[14]), .duplex_change_event(ev[13]),
      .page_rx_event(ev[12]), .an_complete_event(ev[11]), .link_change_event(ev[10]),
      .false_carrier_event(ev[8]), .crossover_change_event(ev[6]), .speed_fallback_event(ev[5]),
      .sleep_change_event(ev[4]), .wake_packet_event(ev[3]), .rgmii_error_event(ev[9]),
      .sgmii_error_event(ev[7]), .sgmii_active(sg), .polarity_change_event(ev[1]), .jabber_event(ev[0]),
      .rx_error, .gig_attempt_fail, .fast_attempt_fail, .cd_no_energy, .fallback_restart, .int_pin,
      .serial_mac_an_enable, .fallback_mask_gig, .fallback_drop_to_ten);
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic conclude;
      $display("compares=%0d bad_count=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // One fallback attempt pulse, then wait for the registered outputs to land
   task automatic fb_step(input logic g, input logic f);
      gig_attempt_fail <= g;
      fast_attempt_fail <= f;
      @(posedge clk);
      gig_attempt_fail <= 1'b0;
      fast_attempt_fail <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   // Hang guard: the saturation run dominates at about 66k cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 80000) begin
         bad_count++;
         conclude();
      end
   end
   initial begin
      for (int k = 0; k < 16; k++) begin
         if (k != 9 && k != 7 && k != 2) rows.push_back({1'b0, 16'h0001 << k, 16'h0001 << k});
      end
      rows.push_back({1'b0, 16'h0200, 16'h0004}); // MAC error follows the selected interface
      rows.push_back({1'b1, 16'h0200, 16'h0000});
      rows.push_back({1'b1, 16'h0080, 16'h0004});
      rows.push_back({1'b0, 16'h0080, 16'h0000});
      repeat (10) @(posedge clk);
      chk({15'h0, int_pin}, 16'h0001);
      rstn <= 1'b1;
      @(posedge clk);
      i_host.rd(`PISC_OFF_EVENT_STATUS, d1, d2);
      chk(d1, 16'h0000);
      i_host.rd(`PISC_OFF_CONFIG_TWO, d1, d2);
      chk(d1, 16'h29C7);
      foreach (rows[i]) begin
         sg <= rows[i][32];
         ien <= rows[i][15:0];
         ev <= rows[i][31:16];
         @(posedge clk);
         ev <= 16'h0000;
         repeat (3) @(posedge clk);
         chk({15'h0, int_pin}, {15'h0, rows[i][15:0] == 16'h0000});
         i_host.rd(`PISC_OFF_EVENT_STATUS, d1, d2);
         chk(d1, rows[i][15:0]);
         chk(d2, 16'h0000);
         repeat (3) @(posedge clk);
         chk({15'h0, int_pin}, 16'h0001);
      end
      // Event in the very cycle of a status read, enables off
      ien <= 16'h0000;
      ev <= 16'h0400;
      fork
         i_host.rd(`PISC_OFF_EVENT_STATUS, d1, d2);
         begin @(posedge clk); ev <= 16'h0000; end
      join
      chk(d2, 16'h0400);
      chk({15'h0, int_pin}, 16'h0001);
      // The second read of the pair above already cleared the bit; a write must not set any
      i_host.wr(`PISC_OFF_EVENT_STATUS, 16'hFFFF);
      i_host.rd(`PISC_OFF_EVENT_STATUS, d1, d2);
      chk(d1, 16'h0000);
      chk(d2, 16'h0000);
      i_host.rd(5'h16, d1, d2);
      chk(d1, 16'h0000);
      i_host.wr(`PISC_OFF_CONFIG_TWO, 16'hFFFF);
      i_host.rd(`PISC_OFF_CONFIG_TWO, d1, d2);
      chk(d1, 16'h2FC7);
      i_host.wr(`PISC_OFF_CONFIG_TWO, 16'h0000);
      i_host.rd(`PISC_OFF_CONFIG_TWO, d1, d2);
      chk(d1, 16'h0007);
      chk({15'h0, serial_mac_an_enable}, 16'h0000);
      chk({15'h0, int_pin}, 16'h0000);
      ien <= 16'h0400;
      ev <= 16'h0400;
      @(posedge clk);
      ev <= 16'h0000;
      repeat (3) @(posedge clk);
      chk({15'h0, int_pin}, 16'h0001);
      i_host.rd(`PISC_OFF_EVENT_STATUS, d1, d2);
      // Every attempt limit code, then the step down to ten
      for (int c = 0; c < 4; c++) begin
         fallback_restart <= 1'b1;
         i_host.wr(`PISC_OFF_CONFIG_TWO, {4'h2, c[1:0], 10'h240});
         fallback_restart <= 1'b0;
         @(posedge clk);
         repeat ((1 << c) - 1) fb_step(1'b1, 1'b0);
         chk({15'h0, fallback_mask_gig}, 16'h0000);
         fb_step(1'b1, 1'b0);
         chk({15'h0, fallback_mask_gig}, 16'h0001);
         fb_step(1'b0, 1'b1);
         chk({15'h0, fallback_drop_to_ten}, 16'h0001);
         i_host.rd(`PISC_OFF_EVENT_STATUS, d1, d2);
         chk(d1 & 16'h0020, 16'h0020);
      end
      // Enhanced mode with no energy on C/D, ten megabit step forbidden
      fallback_restart <= 1'b1;
      i_host.wr(`PISC_OFF_CONFIG_TWO, 16'h2F00);
      fallback_restart <= 1'b0;
      cd_no_energy <= 1'b1;
      @(posedge clk);
      fb_step(1'b1, 1'b0);
      chk({15'h0, fallback_mask_gig}, 16'h0001);
      fb_step(1'b0, 1'b1);
      chk({15'h0, fallback_drop_to_ten}, 16'h0000);
      rx_error <= 1'b1;
      repeat (3) @(posedge clk);
      fork
         i_host.rd(`PISC_OFF_RX_ERR_CNT, d1, d2);
         begin @(posedge clk); rx_error <= 1'b0; end
      join
      chk(d1, 16'h0003);
      chk(d2, 16'h0004);
      i_host.wr(`PISC_OFF_RX_ERR_CNT, 16'hA5A5);
      i_host.rd(`PISC_OFF_RX_ERR_CNT, d1, d2);
      chk(d1, 16'h0000);
      rx_error <= 1'b1;
      repeat (65540) @(posedge clk);
      i_host.rd(`PISC_OFF_RX_ERR_CNT, d1, d2);
      chk(d2, 16'hFFFF);
      conclude();
   end
endmodule
`default_nettype wire
